// *** rtl/pmis_pkg.sv ***
// Shared constants and types for the power monitor serial slave with alert.
package pmis_pkg;
  localparam int CLK_MHZ = 200;
  localparam int STUCK_MS = 33;
  localparam int STUCK_CYC = STUCK_MS * CLK_MHZ * 1000;
  localparam int NUM_REGS = 50;
  localparam logic [2:0] ADDR_TOP = 3'h6;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [6:0] MASS_ADDR = 7'h66;
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_ALERT = 6'h01;
  localparam logic [5:0] REG_STATUS = 6'h02;
  localparam logic [5:0] REG_FAULT = 6'h03;
  localparam logic [5:0] REG_FAULT_LOG_CLEAR_ON_READ = 6'h04;
  localparam logic [5:0] REG_LAST = 6'h31;
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [7:0] ALERT_RST = 8'h00;
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic ARA_REPLY_LSB = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_READ,
    ST_ARA
  } pmis_state_t;
endpackage

// *** rtl/pmis_sync.sv ***
// Two-flop level synchroniser for signals entering a clock domain.
`timescale 1ns/1ps
module pmis_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out <= meta_r;
  end
endmodule

// *** rtl/pmis_top.sv ***
// Serial slave, register store and alert logic of the power monitor.
// Summary of operation
// (R1) Slave pulls data low in the ninth clock slot to acknowledge each byte received.
// (R2) The sender of a byte releases data during its acknowledge slot.
// (R3) Master may end with Stop after the slave leaves acknowledge high.
// (R4) Master pulls data low in the ninth slot to request another read byte.
// (R5) Master ends a read with no acknowledge followed by Stop.
// (R6) Write starts with Start, address with write bit, then a command byte.
// (R7) Command byte is acknowledged and its low six bits load the pointer.
// (R8) Each write data byte is acknowledged and stored at the pointer.
// (R9) Further write bytes advance the pointer by one before storing.
// (R10) Stop ends any transfer and returns the pointer to zero.
// (R11) Repeated Start with read bit is acknowledged, then the register shifts out.
// (R12) Each master acknowledge on a read advances the pointer and sends the next.
// (R13) Alert pulls low while an enabled fault bit is set.
// (R14) After reset all alert enables are clear and alert is released.
// (R15) Alert response address is answered with own address, then alert releases.
// (R16) Reading the fault log or its clear-on-read alias releases alert.
// (R17) A released alert returns only for a new or re-occurring fault bit.
// (R18) Master repeats alert response until the shared alert line goes high.
// (R19) Lowest address wins alert response arbitration and replies first.
// (R20) Data has separate input and output pins; clock is input only.
// (R21) Pointer wraps from 31h to 00h during auto-increment.
// (R22) Clock or data low beyond 33 ms resets the serial engine and releases data.
// (R23) The common broadcast write address is also accepted.
// (R24) Alert response address is not acknowledged without a pending alert.
// (R25) The two top command bits are ignored.
`timescale 1ns/1ps
module pmis_top
  import pmis_pkg::*;
#(
  parameter int STUCK_CYCLES = STUCK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic serial_data_in,
  input wire logic [3:0] addr_sel_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] fault_event_in,
  output logic serial_data_out,
  output logic alert_oe_out,
  output logic [7:0] ctrl_out
);
  localparam int CNT_W = $clog2(STUCK_CYCLES + 1);
  localparam logic [CNT_W-1:0] STUCK_LIMIT = CNT_W'(STUCK_CYCLES);

  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = (p == REG_LAST) ? PTR_RST : p + 6'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Signals crossing between the two domains.
  logic stuck_r, alert_r, ack_tgl_r;
  logic [7:0] rdata_r;
  logic req_tgl_r, req_wr_r, rel_tgl_r;
  logic [5:0] req_addr_r;
  logic [7:0] req_data_r;
  logic rst_s, scl_s, sda_s, stuck_l, pend_l, ack_tgl_l;
  logic [3:0] addr_l;
  logic scl_c, sda_c, req_c, rel_c;

  // The data pin is read and driven on separate ports. (R20)
  pmis_sync #(.W(10)) u_sync_link (
    .clk_in(link_clk_in),
    .d_in({rst_in, scl_in, serial_data_in, stuck_r, alert_r, ack_tgl_r, addr_sel_in}),
    .q_out({rst_s, scl_s, sda_s, stuck_l, pend_l, ack_tgl_l, addr_l})
  );

  pmis_sync #(.W(4)) u_sync_core (
    .clk_in(clk_in),
    .d_in({scl_in, serial_data_in, req_tgl_r, rel_tgl_r}),
    .q_out({scl_c, sda_c, req_c, rel_c})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: bit engine on the oversampled serial clock.
  pmis_state_t state_r, state_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] rx_r, tx_r, tx_nxt;
  logic [5:0] ptr_r, ptr_nxt, req_addr_nxt;
  logic [7:0] req_data_nxt;
  logic scl_p_r, sda_p_r, ack_r, ack_nxt, have_r, have_nxt, sdo_r, sdo_nxt;
  logic ack_seen_r, req_nxt, req_wr_nxt, rel_nxt;

  // A stuck bus holds the engine in reset until both lines are high again.
  wire rst_l = rst_s | stuck_l; // R22
  wire rise = scl_s & ~scl_p_r;
  wire fall = ~scl_s & scl_p_r;
  wire start = scl_s & scl_p_r & sda_p_r & ~sda_s;
  wire stop = scl_s & scl_p_r & ~sda_p_r & sda_s;
  wire [7:0] rx_nxt = {rx_r[6:0], sda_s};
  wire byte_done = rise & (bitcnt_r == LAST_BIT);
  wire ack_rise = rise & (bitcnt_r == ACK_SLOT);
  wire [6:0] own_addr = {ADDR_TOP, addr_l};
  wire hit_own = rx_nxt[7:1] == own_addr;
  wire hit_mass = (rx_nxt[7:1] == MASS_ADDR) & ~rx_nxt[0]; // R23
  wire is_ara = (rx_nxt[7:1] == ARA_ADDR) & rx_nxt[0];
  wire hit_ara = is_ara & pend_l; // R24
  wire tx_mode = (state_r == ST_READ) | (state_r == ST_ARA);
  wire tx_bit = tx_r[~bitcnt_r[2:0]];
  wire ack_new = ack_tgl_l ^ ack_seen_r;
  wire [5:0] ptr_step = ptr_inc(ptr_r); // R21
  wire lost = tx_mode & (bitcnt_r != ACK_SLOT) & tx_bit & ~sda_s; // R19

  always_comb begin
    state_nxt = state_r;
    bitcnt_nxt = bitcnt_r;
    ack_nxt = ack_r;
    ptr_nxt = ptr_r;
    have_nxt = have_r;
    tx_nxt = ack_new ? rdata_r : tx_r;
    sdo_nxt = sdo_r;
    req_nxt = 1'b0;
    req_wr_nxt = req_wr_r;
    req_addr_nxt = req_addr_r;
    req_data_nxt = req_data_r;
    rel_nxt = 1'b0;
    if (stop) begin
      state_nxt = ST_IDLE;
      ptr_nxt = PTR_RST; // R10
      sdo_nxt = 1'b1;
    end else if (start) begin
      state_nxt = ST_ADDR;
      bitcnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      have_nxt = 1'b0;
      sdo_nxt = 1'b1;
    end else if (rise) begin
      bitcnt_nxt = (bitcnt_r == ACK_SLOT) ? 4'h0 : bitcnt_r + 4'h1;
      if (lost) begin
        // Another responder drove low while this one released: back off. (R19)
        state_nxt = ST_IDLE;
        ack_nxt = 1'b0;
      end else if (byte_done) begin
        ack_nxt = 1'b0;
        case (state_r)
          ST_ADDR: begin
            if (hit_ara) begin
              state_nxt = ST_ARA; // R15
              ack_nxt = 1'b1;
              tx_nxt = {own_addr, ARA_REPLY_LSB};
            end else if (hit_own & rx_nxt[0]) begin
              state_nxt = ST_READ; // R11
              ack_nxt = 1'b1;
              req_nxt = 1'b1;
              req_wr_nxt = 1'b0;
              req_addr_nxt = ptr_r;
            end else if (hit_own | hit_mass) begin
              state_nxt = ST_CMD; // R6
              ack_nxt = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
          ST_CMD: begin
            state_nxt = ST_WDATA;
            ack_nxt = 1'b1; // R7
            ptr_nxt = rx_nxt[5:0]; // R25
          end
          ST_WDATA: begin
            ack_nxt = 1'b1; // R8
            have_nxt = 1'b1;
            req_nxt = 1'b1;
            req_wr_nxt = 1'b1;
            req_data_nxt = rx_nxt;
            req_addr_nxt = have_r ? ptr_step : ptr_r; // R9
            ptr_nxt = have_r ? ptr_step : ptr_r;
          end
          ST_ARA: begin
            rel_nxt = 1'b1; // R15
          end
          default: begin
          end
        endcase
      end else if (ack_rise & ~ack_r) begin
        if ((state_r == ST_READ) & ~sda_s) begin
          ptr_nxt = ptr_step; // R12
          req_nxt = 1'b1;
          req_wr_nxt = 1'b0;
          req_addr_nxt = ptr_step;
        end else if (tx_mode) begin
          state_nxt = ST_IDLE;
        end
      end
    end else if (fall) begin
      if (bitcnt_r == ACK_SLOT) begin
        sdo_nxt = ~ack_r; // R1 R2
      end else if (tx_mode) begin
        sdo_nxt = tx_bit;
      end else begin
        sdo_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (rst_l) begin
      state_r <= ST_IDLE;
      bitcnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'hff;
      ptr_r <= PTR_RST;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      ack_r <= 1'b0;
      have_r <= 1'b0;
      sdo_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      rx_r <= rise ? rx_nxt : rx_r;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      ack_r <= ack_nxt;
      have_r <= have_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  // Handshake state survives a stuck-bus reset so both domains stay paired.
  always_ff @(posedge link_clk_in) begin
    if (rst_s) begin
      req_tgl_r <= 1'b0;
      rel_tgl_r <= 1'b0;
      ack_seen_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_addr_r <= PTR_RST;
      req_data_r <= 8'h00;
    end else begin
      req_tgl_r <= req_tgl_r ^ req_nxt;
      rel_tgl_r <= rel_tgl_r ^ rel_nxt;
      ack_seen_r <= ack_tgl_l;
      req_wr_r <= req_wr_nxt;
      req_addr_r <= req_addr_nxt;
      req_data_r <= req_data_nxt;
    end
  end

  assign serial_data_out = sdo_r; // R20

  a_ack_drive: assert property (@(posedge link_clk_in) disable iff (rst_l) // R1
    (fall && bitcnt_r == ACK_SLOT && ack_r && !start && !stop) |=> !serial_data_out)
    else $error("acknowledge not driven low");
  a_tx_release: assert property (@(posedge link_clk_in) disable iff (rst_l) // R2
    (fall && bitcnt_r == ACK_SLOT && tx_mode && !ack_r) |=> serial_data_out)
    else $error("sender kept data low in acknowledge slot");
  a_stop_ptr: assert property (@(posedge link_clk_in) disable iff (rst_l) // R10
    stop |=> (ptr_r == PTR_RST && state_r == ST_IDLE))
    else $error("stop did not clear pointer");
  a_ptr_wrap: assert property (@(posedge link_clk_in) disable iff (rst_l) // R21
    (ptr_r == REG_LAST && ack_rise && !ack_r && state_r == ST_READ && !sda_s) |=>
    ptr_r == PTR_RST)
    else $error("pointer did not wrap");
  a_ara_quiet: assert property (@(posedge link_clk_in) disable iff (rst_l) // R24
    (byte_done && state_r == ST_ADDR && is_ara && !pend_l) |=> (!ack_r && state_r == ST_IDLE))
    else $error("alert response taken with no alert");
  a_cmd_load: assert property (@(posedge link_clk_in) disable iff (rst_l) // R7
    (byte_done && state_r == ST_CMD) |=> (ptr_r == rx_r[5:0] && ack_r))
    else $error("command byte not loaded");
  a_stuck_free: assert property (@(posedge link_clk_in) disable iff (rst_s) // R22
    stuck_l |=> serial_data_out)
    else $error("data driven during stuck bus");

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: register store, fault log, alert and stuck-bus timer.
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] fault_r, served_r;
  logic req_p_r, rel_p_r;
  logic [CNT_W-1:0] stuck_cnt_r;

  wire req_go = req_c ^ req_p_r;
  wire rel_go = rel_c ^ rel_p_r;
  wire wr_go = req_go & req_wr_r;
  wire rd_go = req_go & ~req_wr_r;
  wire is_flt = req_addr_r == REG_FAULT;
  wire is_cor = req_addr_r == REG_FAULT_LOG_CLEAR_ON_READ;
  wire in_map = req_addr_r < 6'(NUM_REGS);
  wire plain_wr = wr_go & in_map & ~is_flt & ~is_cor & (req_addr_r != REG_STATUS);
  wire [7:0] alert_en = regs_r[REG_ALERT];
  wire [7:0] fault_kept = (rd_go & is_cor) ? 8'h00 :
                          (wr_go & is_flt) ? (fault_r & req_data_r) : fault_r;
  wire release_go = rel_go | (rd_go & (is_flt | is_cor)); // R15 R16
  // Served bits stay masked until the matching fault bit is cleared.
  wire [7:0] served_nxt = (release_go ? fault_r : served_r) & fault_kept; // R17
  wire [7:0] alert_hot = fault_r & alert_en & ~served_r;
  wire alert_nxt = |alert_hot; // R13
  wire [7:0] rd_val = (req_addr_r == REG_STATUS) ? status_in :
                      (is_flt | is_cor) ? fault_r :
                      in_map ? regs_r[req_addr_r] : 8'h00;
  wire bus_high = scl_c & sda_c;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RST;
      end
      regs_r[REG_CTRL] <= CTRL_RST;
      regs_r[REG_ALERT] <= ALERT_RST; // R14
    end else if (plain_wr) begin
      regs_r[req_addr_r] <= req_data_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_r <= FAULT_RST;
      served_r <= FAULT_RST;
      alert_r <= 1'b0; // R14
      req_p_r <= 1'b0;
      rel_p_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      // New events win over a clear in the same cycle.
      fault_r <= fault_kept | fault_event_in;
      served_r <= served_nxt;
      alert_r <= alert_nxt;
      req_p_r <= req_c;
      rel_p_r <= rel_c;
      ack_tgl_r <= ack_tgl_r ^ rd_go;
      rdata_r <= rd_go ? rd_val : rdata_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || bus_high) begin
      stuck_cnt_r <= '0;
      stuck_r <= 1'b0;
    end else if (stuck_cnt_r == STUCK_LIMIT) begin
      stuck_r <= 1'b1; // R22
    end else begin
      stuck_cnt_r <= stuck_cnt_r + CNT_W'(1);
    end
  end

  assign alert_oe_out = alert_r;
  assign ctrl_out = regs_r[REG_CTRL];

  a_alert_cause: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    $rose(alert_oe_out) |-> ($past(alert_hot) != 8'h00))
    else $error("alert rose with no enabled new fault");
  a_alert_set: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    (alert_hot != 8'h00) |=> alert_oe_out)
    else $error("enabled fault did not pull alert");
  a_reset_quiet: assert property (@(posedge clk_in) // R14
    $past(rst_in) |-> (!alert_oe_out && alert_en == ALERT_RST))
    else $error("alert active after reset");
  a_release_alert: assert property (@(posedge clk_in) disable iff (rst_in) // R16
    (release_go && fault_event_in == 8'h00 && !plain_wr) ##1
    (fault_event_in == 8'h00 && !plain_wr) |=> !alert_oe_out)
    else $error("alert not released after service");
  a_no_reassert: assert property (@(posedge clk_in) disable iff (rst_in) // R17
    (!alert_oe_out && served_r == fault_r && fault_event_in == 8'h00 && !plain_wr) |=>
    !alert_oe_out)
    else $error("served fault pulled alert again");
endmodule

// *** verification/pmis_master.sv ***
// Behavioural serial bus master that drives the slave's clock and data lines.
`timescale 1ns/1ps
module pmis_master #(
  parameter int HALF = 70
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic start();
    sda_out = 1'b1;
    hold(HALF);
    scl_out = 1'b1;
    hold(HALF);
    sda_out = 1'b0;
    hold(HALF);
    scl_out = 1'b0;
  endtask

  task automatic stop();
    hold(HALF / 4);
    sda_out = 1'b0;
    hold(HALF);
    scl_out = 1'b1;
    hold(HALF);
    sda_out = 1'b1;
    hold(HALF);
  endtask

  // Data moves a quarter phase after the clock falls, so the slave never sees both at once.
  task automatic bit_io(input logic b, output logic s);
    hold(HALF / 4);
    sda_out = b;
    hold(HALF);
    scl_out = 1'b1;
    hold(HALF);
    s = sda_in;
    scl_out = 1'b0;
  endtask

  task automatic send8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    send8(d);
    bit_io(1'b1, ack);
  endtask

  // A second responder is modelled by pulling the wire wherever its reply holds a zero.
  task automatic rbyte_with(input logic [7:0] other, input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(other[i], d[i]);
    bit_io(nack, s);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    rbyte_with(8'hff, nack, d);
  endtask
endmodule

// *** verification/pmis_top_bench.sv ***
// Self-checking bench for the serial slave with alert, driven by a master model.
`timescale 1ns/1ps
module pmis_top_bench
  import pmis_pkg::*;
;
  localparam int STUCK = 3000;
  localparam int LIMIT = 95000;
  localparam logic [3:0] SEL = 4'h8;
  localparam logic [7:0] OWN_W = {3'b110, SEL, 1'b0};
  logic clk_in, link_clk, rst_in, scl, sda_m, sdo, alert_oe;
  logic [7:0] status, fault_ev, ctrl;
  wire logic sda_w;
  int fail_count, samples_checked, cycles;

  // The data wire has a pull-up: low whenever either party pulls it.
  assign sda_w = sda_m & sdo;

  pmis_top #(.STUCK_CYCLES(STUCK)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .link_clk_in(link_clk), .scl_in(scl), .serial_data_in(sda_w), .addr_sel_in(SEL),
    .status_in(status), .fault_event_in(fault_ev), .serial_data_out(sdo),
    .alert_oe_out(alert_oe), .ctrl_out(ctrl));
  pmis_master m (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'b0;
    #3.1;
    forever #7.5 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic pulse(input logic [7:0] v);
    fault_ev = v;
    wait_cyc(1);
    fault_ev = 8'h00;
    wait_cyc(5);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] d0,
                    input logic [7:0] d1, input int n);
    logic a;
    m.start();
    m.wbyte(adr, a);
    check("addr ack", {7'h00, a}, 8'h00);
    m.wbyte(cmd, a);
    check("cmd ack", {7'h00, a}, 8'h00);
    m.wbyte(d0, a);
    check("data ack", {7'h00, a}, 8'h00);
    if (n > 1) begin
      m.wbyte(d1, a);
      check("data2 ack", {7'h00, a}, 8'h00);
    end
    m.stop();
    wait_cyc(30);
  endtask

  task automatic rd(input logic use_cmd, input logic [7:0] cmd, input logic [7:0] e0,
                    input logic [7:0] e1, input int n);
    logic a;
    logic [7:0] d;
    if (use_cmd) begin
      m.start();
      m.wbyte(OWN_W, a);
      m.wbyte(cmd, a);
    end
    m.start();
    m.wbyte(OWN_W | 8'h01, a);
    check("read ack", {7'h00, a}, 8'h00);
    m.rbyte(n < 2, d);
    check("read byte", d, e0);
    if (n > 1) begin
      m.rbyte(1'b1, d);
      check("next byte", d, e1);
    end
    m.stop();
    wait_cyc(30);
  endtask

  // The master repeats this while the shared alert line stays low.
  // A rival of all ones means no other responder is on the wire.
  task automatic ara(input logic exp_ack, input logic [7:0] rival);
    logic a;
    logic [7:0] d;
    m.start();
    m.wbyte({ARA_ADDR, 1'b1}, a);
    check("ara ack", {7'h00, a}, {7'h00, ~exp_ack});
    if (a === 1'b0) begin
      m.rbyte_with(rival, 1'b1, d);
      check("ara reply", d, (rival < OWN_W) ? rival : OWN_W);
    end
    m.stop();
    wait_cyc(30);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("ctrl reset", ctrl, CTRL_RST);
    check("alert reset", {7'h00, alert_oe}, 8'h00);
    check("data reset", {7'h00, sdo}, 8'h01);
  endtask

  task automatic t_write_read();
    wr(OWN_W, 8'hc0, 8'h3c, 8'h01, 2);
    check("ctrl write", ctrl, 8'h3c);
    rd(1'b1, 8'h01, 8'h01, status, 2);
  endtask

  task automatic t_wrap();
    wr(OWN_W, {2'b00, REG_LAST}, 8'haa, 8'hbb, 2);
    check("ctrl wrap", ctrl, 8'hbb);
    rd(1'b1, {2'b00, REG_LAST}, 8'haa, 8'hbb, 2);
    rd(1'b0, 8'h00, 8'hbb, 8'h00, 1);
  endtask

  task automatic t_alert();
    pulse(8'h01);
    check("alert set", {7'h00, alert_oe}, 8'h01);
    ara(1'b1, 8'hff);
    check("alert served", {7'h00, alert_oe}, 8'h00);
    ara(1'b0, 8'hff);
    pulse(8'h01);
    check("alert repeat", {7'h00, alert_oe}, 8'h00);
    wr(OWN_W, {2'b00, REG_FAULT}, 8'h00, 8'h00, 1);
    pulse(8'h01);
    check("alert again", {7'h00, alert_oe}, 8'h01);
    rd(1'b1, {2'b00, REG_FAULT_LOG_CLEAR_ON_READ}, 8'h01, 8'h00, 1);
    check("alert cor", {7'h00, alert_oe}, 8'h00);
    rd(1'b1, {2'b00, REG_FAULT}, 8'h00, 8'h00, 1);
  endtask

  // A lower-addressed rival wins the first reply, so alert must stay until the retry.
  task automatic t_arbitrate();
    pulse(8'h01);
    ara(1'b1, 8'hce);
    check("alert kept", {7'h00, alert_oe}, 8'h01);
    ara(1'b1, 8'hff);
    check("alert won", {7'h00, alert_oe}, 8'h00);
  endtask

  task automatic t_address();
    logic a;
    wr({MASS_ADDR, 1'b0}, 8'h00, 8'h5a, 8'h00, 1);
    check("ctrl mass", ctrl, 8'h5a);
    m.start();
    m.wbyte(OWN_W ^ 8'h02, a);
    check("foreign nack", {7'h00, a}, 8'h01);
    m.stop();
    wait_cyc(30);
  endtask

  task automatic t_stuck();
    m.start();
    m.send8(OWN_W);
    wait_cyc(20);
    check("ack held", {7'h00, sdo}, 8'h00);
    wait_cyc(STUCK + 100);
    check("stuck release", {7'h00, sdo}, 8'h01);
    m.stop();
    rd(1'b0, 8'h00, 8'h5a, 8'h00, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    rst_in = 1'b1;
    status = 8'h9c;
    fault_ev = 8'h00;
    wait_cyc(20);
    rst_in = 1'b0;
    t_reset();
    wait_cyc(10);
    t_write_read();
    t_wrap();
    t_alert();
    t_arbitrate();
    t_address();
    t_stuck();
    end_of_test();
  end
endmodule
